// ===== rtl/boost_seq_defs.svh
// Timing, level and width constants for the boost startup and fault sequencer.
`ifndef BOOST_SEQ_DEFS_SVH
`define BOOST_SEQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and time bases
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define CYC_PER_US (1000 / `CLK_PERIOD_NS)
`define CYC_PER_MS (1000 * `CYC_PER_US)

// ----------------------------------------------------------------------------
// Phase timeouts, each as printed and as a cycle count
// ----------------------------------------------------------------------------
`define T_PRE1_US 512
`define T_PRE2_US 1024
`define T_SS_OVL_US 64
`define T_BOOST_OVL_MS 2
`define T_RESTART_MS 20
`define PRE1_CYC (`T_PRE1_US * `CYC_PER_US)
`define PRE2_CYC (`T_PRE2_US * `CYC_PER_US)
`define SS_OVL_CYC (`T_SS_OVL_US * `CYC_PER_US)
`define BOOST_OVL_CYC (`T_BOOST_OVL_MS * `CYC_PER_MS)
`define RESTART_CYC (`T_RESTART_MS * `CYC_PER_MS)

// ----------------------------------------------------------------------------
// Counter widths and analog settings
// ----------------------------------------------------------------------------
`define CNT_W 18
`define PRECHG_TYP_MA 8'h5a
`define PRECHG_MAX_MA 8'hc8
`define PRECHG_OFF_MA 8'h00
`define PULSE_HALF_PCT 7'h32
`define PULSE_FULL_PCT 7'h64
`define SS_REF_ZERO 8'h00
`define SS_REF_FULL 8'hff
`define SS_STEP_CYC 5'h04
`define SS_SLOW_CYC 5'h10
`define SW_DIV_LAST 2'h3
`define SW_HIGH_END 2'h2

`endif

// ===== rtl/boost_seq_pkg.sv
// Types shared by the boost startup and fault sequencer.
package boost_seq_pkg;

    // ------------------------------------------------------------------------
    // Sequencer modes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SHUTDOWN,
        MODE_PRECHARGE_FIRST,
        MODE_PRECHARGE_SECOND,
        MODE_SOFT_START,
        MODE_BOOST_REGULATE,
        MODE_FAULT
    } seq_mode_type;

endpackage

// ===== rtl/phase_timer.sv
// Clearable cycle counter that flags the last cycle of a programmed interval.
`timescale 1ns/1ps
module phase_timer #(
    parameter int WIDTH = 18
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clear_i,
    input wire logic run_i,
    input wire logic [WIDTH-1:0] limit_i,
    output logic expired_o
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // ------------------------------------------------------------------------
    // Count while running; saturate so a long stay never wraps to zero.
    // ------------------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        if (clear_i) begin
            count_d = '0;
        end else if (run_i && (count_q != '1)) begin
            count_d = count_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // The flag marks the cycle in which the interval is complete.
    // Clear stays out of the flag: callers clear on their own next state, and a
    // flag that looked at clear would close a combinational loop through them.
    assign expired_o = run_i && (count_q >= (limit_i - 1'b1));

endmodule // phase_timer

// ===== rtl/boost_startup_fault_sequencer.sv
// Mode and fault sequencer of a fixed-output boost regulator.
`timescale 1ns/1ps
`include "boost_seq_defs.svh"
module boost_startup_fault_sequencer
    import boost_seq_pkg::*;
#(
    parameter int PRE1_CYCLES = `PRE1_CYC,
    parameter int PRE2_CYCLES = `PRE2_CYC,
    parameter int BOOST_OVL_CYCLES = `BOOST_OVL_CYC,
    parameter int RESTART_CYCLES = `RESTART_CYC
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic input_undervoltage_i,
    input wire logic output_near_input_i,
    input wire logic output_at_target_i,
    input wire logic current_limit_i,
    input wire logic input_above_output_i,
    input wire logic die_hot_i,
    input wire logic die_cooled_i,
    input wire logic discontinuous_conduction_i,
    input wire logic pulse_demand_i,
    output seq_mode_type mode_o,
    output logic bias_en_o,
    output logic isolate_o,
    output logic precharge_en_o,
    output logic [7:0] precharge_current_limit_o,
    output logic switch_en_o,
    output logic [6:0] pulse_limit_pct_o,
    output logic [7:0] ss_ref_o,
    output logic sw_clk_o,
    output logic fault_event_o,
    output logic thermal_shutdown_o
);

    localparam int CW = `CNT_W;

    seq_mode_type mode_q;
    seq_mode_type mode_d;
    logic hot_q;
    logic hot_d;
    logic mode_change;
    logic phase_run;
    logic phase_expired;
    logic ovl_run;
    logic ovl_expired;
    logic [CW-1:0] phase_limit;
    logic [CW-1:0] ovl_limit;

    // ------------------------------------------------------------------------
    // Thermal latch
    // ------------------------------------------------------------------------
    // A new hot report wins over a cooled report in the same cycle.
    always_comb begin
        hot_d = hot_q;
        if (die_hot_i) begin
            hot_d = 1'b1;
        end else if (die_cooled_i) begin
            hot_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hot_q <= 1'b0;
        end else begin
            hot_q <= hot_d;
        end
    end

    // ------------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        if (!enable_i) begin
            mode_d = MODE_SHUTDOWN;
        end else if (die_hot_i || hot_q) begin
            mode_d = MODE_SHUTDOWN;
        end else begin
            unique case (mode_q)
                MODE_SHUTDOWN: begin
                    if (!input_undervoltage_i) begin
                        mode_d = MODE_PRECHARGE_FIRST;
                    end
                end
                MODE_PRECHARGE_FIRST: begin
                    if (input_undervoltage_i) begin
                        mode_d = MODE_FAULT;
                    end else if (output_near_input_i) begin
                        mode_d = MODE_SOFT_START;
                    end else if (phase_expired) begin
                        mode_d = MODE_PRECHARGE_SECOND;
                    end
                end
                MODE_PRECHARGE_SECOND: begin
                    if (input_undervoltage_i) begin
                        mode_d = MODE_FAULT;
                    end else if (output_near_input_i) begin
                        mode_d = MODE_SOFT_START;
                    end else if (phase_expired) begin
                        mode_d = MODE_FAULT;
                    end
                end
                MODE_SOFT_START: begin
                    if (input_undervoltage_i) begin
                        mode_d = MODE_FAULT;
                    end else if (output_at_target_i) begin
                        mode_d = MODE_BOOST_REGULATE;
                    end else if (ovl_expired) begin
                        mode_d = MODE_FAULT;
                    end
                end
                MODE_BOOST_REGULATE: begin
                    if (input_undervoltage_i || input_above_output_i || ovl_expired) begin
                        mode_d = MODE_FAULT;
                    end
                end
                MODE_FAULT: begin
                    if (phase_expired) begin
                        mode_d = input_undervoltage_i ? MODE_SHUTDOWN : MODE_PRECHARGE_FIRST;
                    end
                end
                default: begin
                    mode_d = MODE_SHUTDOWN;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mode_q <= MODE_SHUTDOWN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------------
    // Phase and overload timers
    // ------------------------------------------------------------------------
    // Any mode change clears both timers, so a restart begins from zero.
    assign mode_change = (mode_d != mode_q);
    assign phase_run = (mode_q == MODE_PRECHARGE_FIRST) || (mode_q == MODE_PRECHARGE_SECOND)
        || (mode_q == MODE_FAULT);
    assign ovl_run = current_limit_i
        && ((mode_q == MODE_SOFT_START) || (mode_q == MODE_BOOST_REGULATE));

    // The overload limit depends on the phase in which the limit trips.
    always_comb begin
        phase_limit = CW'(RESTART_CYCLES);
        ovl_limit = CW'(BOOST_OVL_CYCLES);
        if (mode_q == MODE_PRECHARGE_FIRST) begin
            phase_limit = CW'(PRE1_CYCLES);
        end else if (mode_q == MODE_PRECHARGE_SECOND) begin
            phase_limit = CW'(PRE2_CYCLES);
        end
        if (mode_q == MODE_SOFT_START) begin
            ovl_limit = CW'(`SS_OVL_CYC);
        end
    end

    phase_timer #(
        .WIDTH(CW)
    ) u_phase_timer (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(mode_change),
        .run_i(phase_run),
        .limit_i(phase_limit),
        .expired_o(phase_expired)
    );

    phase_timer #(
        .WIDTH(CW)
    ) u_ovl_timer (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(mode_change || !current_limit_i),
        .run_i(ovl_run),
        .limit_i(ovl_limit),
        .expired_o(ovl_expired)
    );

    // ------------------------------------------------------------------------
    // Power stage controls
    // ------------------------------------------------------------------------
    logic bias_d;
    logic iso_d;
    logic pre_d;
    logic sw_d;
    logic [7:0] prechg_d;
    logic [6:0] pulse_d;
    logic fault_ev_d;

    // Controls follow the next mode so they line up with mode_o.
    always_comb begin
        bias_d = (mode_d != MODE_SHUTDOWN);
        iso_d = (mode_d == MODE_SHUTDOWN) || (mode_d == MODE_FAULT);
        pre_d = (mode_d == MODE_PRECHARGE_FIRST) || (mode_d == MODE_PRECHARGE_SECOND);
        sw_d = (mode_d == MODE_SOFT_START) || (mode_d == MODE_BOOST_REGULATE);
        prechg_d = pre_d ? `PRECHG_TYP_MA : `PRECHG_OFF_MA;
        if (prechg_d > `PRECHG_MAX_MA) begin
            prechg_d = `PRECHG_MAX_MA;
        end
        pulse_d = (mode_d == MODE_SOFT_START) ? `PULSE_HALF_PCT : `PULSE_FULL_PCT;
        fault_ev_d = (mode_d == MODE_FAULT) && (mode_q != MODE_FAULT);
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            bias_en_o <= 1'b0;
            isolate_o <= 1'b1;
            precharge_en_o <= 1'b0;
            switch_en_o <= 1'b0;
            precharge_current_limit_o <= `PRECHG_OFF_MA;
            pulse_limit_pct_o <= `PULSE_FULL_PCT;
            fault_event_o <= 1'b0;
        end else begin
            bias_en_o <= bias_d;
            isolate_o <= iso_d;
            precharge_en_o <= pre_d;
            switch_en_o <= sw_d;
            precharge_current_limit_o <= prechg_d;
            pulse_limit_pct_o <= pulse_d;
            fault_event_o <= fault_ev_d;
        end
    end

    assign mode_o = mode_q;
    assign thermal_shutdown_o = hot_q;

    // ------------------------------------------------------------------------
    // Soft-start reference and switching clock
    // ------------------------------------------------------------------------
    logic [7:0] ref_q;
    logic [7:0] ref_d;
    logic [4:0] step_q;
    logic [4:0] step_d;
    logic [1:0] div_q;
    logic [1:0] div_d;
    logic go_q;
    logic go_d;
    logic clk_d;

    always_comb begin
        ref_d = ref_q;
        step_d = step_q + 1'b1;
        if (mode_d == MODE_BOOST_REGULATE) begin
            ref_d = `SS_REF_FULL;
            step_d = '0;
        end else if (mode_d != MODE_SOFT_START) begin
            ref_d = `SS_REF_ZERO;
            step_d = '0;
        end else if (step_q >= ((current_limit_i ? `SS_SLOW_CYC : `SS_STEP_CYC) - 1'b1)) begin
            step_d = '0;
            if (ref_q != `SS_REF_FULL) begin
                ref_d = ref_q + 1'b1;
            end
        end
        // divide by four, skip light-load periods.
        div_d = sw_d ? div_q + 1'b1 : '0;
        go_d = go_q;
        if (!sw_d) begin
            go_d = 1'b0;
        end else if (div_q == `SW_DIV_LAST || !switch_en_o) begin
            go_d = !discontinuous_conduction_i || pulse_demand_i;
        end
        clk_d = go_d && (div_d < `SW_HIGH_END);
    end

    // Skipping whole periods keeps each pulse after the first (one cycle) full width, so light load trades
    // frequency for efficiency without narrowing any on-time.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ref_q <= `SS_REF_ZERO;
            step_q <= '0;
            div_q <= '0;
            go_q <= 1'b0;
            sw_clk_o <= 1'b0;
        end else begin
            ref_q <= ref_d;
            step_q <= step_d;
            div_q <= div_d;
            go_q <= go_d;
            sw_clk_o <= clk_d;
        end
    end

    assign ss_ref_o = ref_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    logic [CW-1:0] dwell_q;
    logic [CW-1:0] dwell_d;

    // Cycles spent in the current mode, only for the checks below.
    always_comb begin
        dwell_d = dwell_q;
        if (mode_change) begin
            dwell_d = '0;
        end else if (dwell_q != '1) begin
            dwell_d = dwell_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dwell_q <= '0;
        end else begin
            dwell_q <= dwell_d;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_enter_fault;
        (mode_q != MODE_FAULT) ##1 (mode_q == MODE_FAULT);
    endsequence

    sequence s_leave_fault;
        (mode_q == MODE_FAULT) ##1 (mode_q != MODE_FAULT);
    endsequence

    property p_disable_shutdown;
        !enable_i |=> (mode_q == MODE_SHUTDOWN) && !bias_en_o && (dwell_q == '0 || $past(mode_q) == MODE_SHUTDOWN);
    endproperty
    a_disable_shutdown: assert property (p_disable_shutdown) else $error("enable low did not shut down");

    property p_shutdown_isolated;
        (mode_q == MODE_SHUTDOWN) |-> isolate_o && !precharge_en_o && !switch_en_o;
    endproperty
    a_shutdown_isolated: assert property (p_shutdown_isolated) else $error("shutdown not isolated");

    property p_start_precharge;
        (mode_q == MODE_SHUTDOWN) && enable_i && !input_undervoltage_i && !hot_q && !die_hot_i
            |=> (mode_q == MODE_PRECHARGE_FIRST) && precharge_en_o;
    endproperty
    a_start_precharge: assert property (p_start_precharge) else $error("precharge did not start");

    property p_precharge_level;
        (precharge_current_limit_o <= `PRECHG_MAX_MA)
            && (precharge_en_o == (precharge_current_limit_o == `PRECHG_TYP_MA));
    endproperty
    a_precharge_level: assert property (p_precharge_level) else $error("precharge current wrong");

    property p_near_to_soft;
        ((mode_q == MODE_PRECHARGE_FIRST) || (mode_q == MODE_PRECHARGE_SECOND)) && enable_i
            && !hot_q && !die_hot_i && !input_undervoltage_i && output_near_input_i
            |=> (mode_q == MODE_SOFT_START) ##0 switch_en_o;
    endproperty
    a_near_to_soft: assert property (p_near_to_soft) else $error("precharge exit missed");

    property p_pre1_bound;
        (mode_q == MODE_PRECHARGE_FIRST) |-> (dwell_q < CW'(PRE1_CYCLES));
    endproperty
    a_pre1_bound: assert property (p_pre1_bound) else $error("first precharge overstayed");

    property p_pre2_bound;
        (mode_q == MODE_PRECHARGE_SECOND) |-> (dwell_q < CW'(PRE2_CYCLES));
    endproperty
    a_pre2_bound: assert property (p_pre2_bound) else $error("second precharge overstayed");

    property p_soft_half_limit;
        (mode_q == MODE_SOFT_START) |-> switch_en_o && (pulse_limit_pct_o == `PULSE_HALF_PCT);
    endproperty
    a_soft_half_limit: assert property (p_soft_half_limit) else $error("soft-start limit wrong");

    property p_target_to_boost;
        (mode_q == MODE_SOFT_START) && enable_i && !hot_q && !die_hot_i
            && !input_undervoltage_i && output_at_target_i |=> (mode_q == MODE_BOOST_REGULATE);
    endproperty
    a_target_to_boost: assert property (p_target_to_boost) else $error("no boost entry");

    property p_vin_fault_boost_only;
        s_enter_fault |-> $past(mode_q) == MODE_BOOST_REGULATE || $past(input_undervoltage_i)
            || $past(phase_expired) || $past(ovl_expired);
    endproperty
    a_vin_fault_boost_only: assert property (p_vin_fault_boost_only) else $error("fault cause");

    property p_fault_stage_off;
        (mode_q == MODE_FAULT) |-> isolate_o && !switch_en_o && !sw_clk_o && fault_event_o == (dwell_q == '0);
    endproperty
    a_fault_stage_off: assert property (p_fault_stage_off) else $error("fault state not safe");

    property p_restart_wait;
        s_leave_fault |-> !$past(enable_i) || $past(hot_q) || $past(die_hot_i)
            || ($past(dwell_q) == CW'(RESTART_CYCLES - 1));
    endproperty
    a_restart_wait: assert property (p_restart_wait) else $error("restart wait wrong");

endmodule // boost_startup_fault_sequencer

// ===== dv/analog_stage_model.sv
// Behavioural model of the power stage, its comparators and the load.
`timescale 1ns/1ps
module analog_stage_model (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic precharge_en_i,
    input wire logic switch_en_i,
    input wire logic isolate_i,
    input wire logic [1:0] rate_i,
    input wire logic overload_i,
    input wire logic dropout_i,
    input wire logic light_i,
    input wire logic demand_i,
    output logic near_o,
    output logic target_o,
    output logic climit_o,
    output logic above_o,
    output logic light_o,
    output logic demand_o
);
    // ------------------------------------------------------------------
    // Output voltage in arbitrary steps
    // ------------------------------------------------------------------
    logic [7:0] vout_q;
    logic [7:0] vout_d;

    // no startup load
    // No load is drawn before startup ends, so only the stage moves the output.
    // A rate of zero models a shorted output that never charges.
    always_comb begin
        vout_d = vout_q;
        if (isolate_i) begin
            vout_d = 8'h00; // An isolated output drops to zero in one cycle.
        end else if ((precharge_en_i || (switch_en_i && !overload_i)) && vout_q < 8'hf0) begin
            vout_d = vout_q + {6'h00, rate_i};
        end
    end

    // Output level register.
    always_ff @(posedge core_clk_i) begin
        vout_q <= sys_rst_i ? 8'h00 : vout_d;
    end

    // An overload shows as current limit only while the switch runs.
    assign near_o = (vout_q >= 8'h0a);
    assign target_o = (vout_q >= 8'h28);
    assign climit_o = overload_i && switch_en_i;
    assign above_o = dropout_i;
    assign light_o = light_i;
    assign demand_o = demand_i;
endmodule // analog_stage_model

// ===== dv/boost_startup_fault_sequencer_tb.sv
// Self-checking bench for the boost startup and fault sequencer.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module boost_startup_fault_sequencer_tb import boost_seq_pkg::*;;
    // ------------------------------------------------------------------
    // Signals, clock and instances
    // ------------------------------------------------------------------
    logic core_clk, sys_rst, en, input_undervoltage, hot, cooled, overload, dropout, light, demand;
    logic [1:0] rate;
    logic near, target, climit, above, light_w, pdem;
    seq_mode_type mode;
    logic bias, iso, pre_en, sw_en, sw_clk, fault_ev, therm;
    logic [7:0] pre_lim, ss_ref;
    logic [6:0] pulse_pct;
    int bad_count = 0;
    int num_checks = 0;
    int n;

    // Free-running 10 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Short timeouts keep the run brief; expectations use the same values.
    boost_startup_fault_sequencer #(
        .PRE1_CYCLES(20), .PRE2_CYCLES(40), .BOOST_OVL_CYCLES(30), .RESTART_CYCLES(50)
    ) u_dut (
        .core_clk_i(core_clk), .sys_rst_i(sys_rst), .enable_i(en), .input_undervoltage_i(input_undervoltage),
        .output_near_input_i(near), .output_at_target_i(target), .current_limit_i(climit),
        .input_above_output_i(above), .die_hot_i(hot), .die_cooled_i(cooled),
        .discontinuous_conduction_i(light_w), .pulse_demand_i(pdem), .mode_o(mode),
        .bias_en_o(bias), .isolate_o(iso), .precharge_en_o(pre_en),
        .precharge_current_limit_o(pre_lim), .switch_en_o(sw_en), .pulse_limit_pct_o(pulse_pct),
        .ss_ref_o(ss_ref), .sw_clk_o(sw_clk), .fault_event_o(fault_ev), .thermal_shutdown_o(therm)
    );

    analog_stage_model u_stage (
        .core_clk_i(core_clk), .sys_rst_i(sys_rst), .precharge_en_i(pre_en), .switch_en_i(sw_en),
        .isolate_i(iso), .rate_i(rate), .overload_i(overload), .dropout_i(dropout),
        .light_i(light), .demand_i(demand), .near_o(near), .target_o(target),
        .climit_o(climit), .above_o(above), .light_o(light_w), .demand_o(pdem)
    );

    // ------------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------------
    // Inputs always move 1 ns after the edge, so outputs are settled when read.
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // Bounded wait for a mode; n returns the cycles taken.
    task automatic wait_mode(input seq_mode_type m, input int lim);
        n = 0;
        while (mode !== m && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    // Counts high samples of the switching clock.
    task automatic cnt_high(input int k);
        n = 0;
        repeat (k) begin
            tick(1);
            n += int'(sw_clk === 1'b1);
        end
    endtask

    // Fresh start from shutdown into boost regulation.
    task automatic to_boost();
        en = 1'b0;
        tick(1);
        en = 1'b1;
        wait_mode(MODE_BOOST_REGULATE, 200);
        `CHK(mode, MODE_BOOST_REGULATE)
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_start();
        input_undervoltage = 1'b1;
        en = 1'b1;
        tick(5);
        `CHK(mode, MODE_SHUTDOWN)
        input_undervoltage = 1'b0;
        wait_mode(MODE_PRECHARGE_FIRST, 5);
        `CHK(n, 1)
        `CHK({bias, iso, pre_en, pre_lim}, {3'h5, 8'h5a})
        wait_mode(MODE_SOFT_START, 20);
        `CHK({mode, sw_en, pre_en, pulse_pct}, {MODE_SOFT_START, 2'h2, 7'h32})
        wait_mode(MODE_BOOST_REGULATE, 100);
        `CHK({mode, pulse_pct, ss_ref}, {MODE_BOOST_REGULATE, 7'h64, 8'hff})
        cnt_high(40);
        `CHK(n, 20)
        light = 1'b1;
        tick(4);
        cnt_high(40);
        `CHK(n, 0)
        demand = 1'b1;
        tick(4);
        cnt_high(40);
        `CHK(n, 20)
        {light, demand} = 2'h0;
    endtask

    task automatic t_timeout();
        en = 1'b0;
        tick(1);
        `CHK({mode, bias, iso, sw_en}, {MODE_SHUTDOWN, 3'h2})
        rate = 2'h0;
        en = 1'b1;
        wait_mode(MODE_PRECHARGE_FIRST, 5);
        wait_mode(MODE_PRECHARGE_SECOND, 100);
        `CHK(n, 20)
        `CHK(pre_lim, 8'h5a)
        wait_mode(MODE_FAULT, 100);
        `CHK(n, 40)
        `CHK({fault_ev, sw_en, iso, pre_en}, 4'ha)
        tick(1);
        `CHK(fault_ev, 1'b0)
        wait_mode(MODE_PRECHARGE_FIRST, 100);
        `CHK(n, 49)
        wait_mode(MODE_PRECHARGE_SECOND, 100);
        `CHK(n, 20)
        tick(3);
        en = 1'b0;
        tick(1);
        `CHK(mode, MODE_SHUTDOWN)
        rate = 2'h1;
    endtask

    task automatic t_ss_overload();
        overload = 1'b1;
        en = 1'b1;
        wait_mode(MODE_SOFT_START, 40);
        tick(160);
        `CHK(ss_ref, 8'h0a)
        wait_mode(MODE_FAULT, 700);
        `CHK(n, 480)
        overload = 1'b0;
    endtask

    task automatic t_boost_faults();
        to_boost();
        overload = 1'b1;
        wait_mode(MODE_FAULT, 100);
        `CHK(n inside {30, 31}, 1'b1)
        overload = 1'b0;
        dropout = 1'b1;
        to_boost();
        wait_mode(MODE_FAULT, 5);
        `CHK(n, 1)
        dropout = 1'b0;
        to_boost();
        input_undervoltage = 1'b1;
        wait_mode(MODE_FAULT, 5);
        `CHK(n, 1)
        en = 1'b0;
        wait_mode(MODE_SHUTDOWN, 5);
        `CHK({n == 1, bias}, 2'h2)
        input_undervoltage = 1'b0;
    endtask

    task automatic t_thermal();
        to_boost();
        hot = 1'b1;
        wait_mode(MODE_SHUTDOWN, 5);
        `CHK({n == 1, therm, sw_en}, 3'h6)
        hot = 1'b0;
        tick(5);
        `CHK({mode, therm}, {MODE_SHUTDOWN, 1'b1})
        cooled = 1'b1;
        wait_mode(MODE_PRECHARGE_FIRST, 5);
        `CHK({n < 5, therm}, 2'h2)
        cooled = 1'b0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: three cycles of reset, then each scenario in turn.
    initial begin
        sys_rst = 1'b1;
        {en, input_undervoltage, hot, cooled, overload, dropout, light, demand} = 8'h00;
        rate = 2'h1;
        repeat (3) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        `CHK({mode, bias, iso, pre_en, sw_en, pulse_pct}, {MODE_SHUTDOWN, 4'h4, 7'h64})
        t_start();
        t_timeout();
        t_ss_overload();
        t_boost_faults();
        t_thermal();
        wrap_up();
    end

    // Watchdog well beyond the expected 120 us of traffic.
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end
endmodule // boost_startup_fault_sequencer_tb
